// ==== rcb_cfg.svh ====
// Offsets, field positions, reset values and counts for start-up control.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RCB_CFG_SVH
`define RCB_CFG_SVH

// PLL lock interval in reference clock cycles
`define LOCK_CYCLES 13'h1000
`define LOCK_CNT_W 13

// Register byte offsets on the APB
`define OFS_STATUS 8'h00
`define OFS_PCC 8'h04
`define OFS_RRC 8'h08

// Power and clock control fields
`define PCC_MULT_LSB 0
`define PCC_MULT_MSB 5
`define PCC_DIV_LSB 8
`define PCC_DIV_MSB 9
`define DIV_RESET 2'h0

// Running reset control field
`define RRC_MODE_BIT 0

// Multiplier per clock-ratio strap code
`define MULT_RATIO_00 6'h08
`define MULT_RATIO_01 6'h20
`define MULT_RATIO_10 6'h10

// Status fields
`define ST_STATE_LSB 0
`define ST_RATIO_LSB 2
`define ST_BOOT_LSB 4
`define ST_BADRATIO_BIT 7
`define ST_RUN_BIT 8
`define ST_PIN_BIT 9

// Hardware reset vector (plain default)
`define RESET_VECTOR 32'h0000_0000

`endif

// ==== rcb_pkg.sv ====
// Types shared by the start-up control modules.
// Assumes rcb_cfg.svh is on the include path.
package rcb_pkg;
  `include "rcb_cfg.svh"

  // Sequencer states, Gray along LOCK -> RUN <-> RUNRST
  typedef enum logic [1:0] {
    ST_LOCK = 2'h0,
    ST_RUN = 2'h1,
    ST_RUNRST = 2'h3
  } seq_state_t;

  typedef logic [1:0] ratio_code_t;
  typedef logic [2:0] boot_mode_t;
  typedef logic [5:0] pll_mult_t;
  typedef logic [1:0] div_code_t;
  typedef logic [`LOCK_CNT_W-1:0] lock_cnt_t;
endpackage : rcb_pkg

// ==== pll_lock_timer.sv ====
// PLL lock interval counter.
// Assumes one clock and the same asynchronous reset as its parent.
`timescale 1ns/100ps
`include "rcb_cfg.svh"
module pll_lock_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  // Result
  output rcb_pkg::lock_cnt_t count,
  output logic done
);
  import rcb_pkg::*;

  localparam lock_cnt_t LAST = lock_cnt_t'(`LOCK_CYCLES - 1);

  lock_cnt_t cnt_q; // Edges counted while running since reset release, held at LAST
  lock_cnt_t cnt_d;

  // Counts while running, stops on the last cycle
  always_comb begin
    done = run && (cnt_q == LAST);
    cnt_d = cnt_q;
    if (run && !done) begin
      cnt_d = cnt_q + lock_cnt_t'(1);
    end
  end

  // Register only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;

  // Counter never passes the lock length
  a_count_bound: assert property (@(posedge clk) disable iff (!rstn)
    cnt_q <= LAST) else $error("lock counter overran");

endmodule : pll_lock_timer

// ==== reset_clock_boot_ctrl.sv ====
// Start-up control: straps, PLL lock wait, shared reset pin, test output.
// Assumes MCLK is the free-running reference clock and RSTN the reset pin.
`timescale 1ns/100ps
`include "rcb_cfg.svh"
module reset_clock_boot_ctrl (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Strap pins
  input wire logic [1:0] CLK_RATIO_STRAP,
  input wire logic [2:0] BOOT_MODE_STRAP,
  // Shared reset pin, output enable low while driving
  input wire logic RESET_PIN_I,
  output logic RESET_PIN_O,
  output logic RESET_PIN_OE_N,
  // Test access port scan path
  input wire logic SCAN_ACTIVE,
  input wire logic SCAN_DATA,
  output logic TDO_O,
  output logic TDO_OE_N,
  // Clock generator controls
  output rcb_pkg::pll_mult_t PLL_MULT,
  output logic [4:0] PLL_DIV_VALUE,
  // Core and peripheral control
  output logic CORE_RSTN,
  output logic PERIPH_RSTN,
  output logic FETCH_START,
  output logic [31:0] FETCH_ADDR,
  output logic BOOT_START,
  output rcb_pkg::boot_mode_t BOOT_MODE,
  output rcb_pkg::seq_state_t SEQ_STATE
);
  import rcb_pkg::*;

  // Ratio strap decode; reserved code falls back to the slowest ratio
  function automatic pll_mult_t ratio_mult(input ratio_code_t code);
    unique case (code)
      2'h0: ratio_mult = `MULT_RATIO_00;
      2'h1: ratio_mult = `MULT_RATIO_01;
      2'h2: ratio_mult = `MULT_RATIO_10;
      default: ratio_mult = `MULT_RATIO_00;
    endcase
  endfunction : ratio_mult

  // Divider code to divide value: 2, 4, 8 or 16
  function automatic logic [4:0] div_value(input div_code_t code);
    div_value = 5'h02 << code;
  endfunction : div_value

  // Pin synchronisers
  ratio_code_t ratio_s1_q, ratio_s2_q;
  boot_mode_t boot_s1_q, boot_s2_q;
  logic pin_s1_q, pin_s2_q;

  // Sequencer
  seq_state_t st_q, st_d;
  logic core_rstn_q, core_rstn_d;
  logic fetch_q, fetch_d;
  logic boot_q, boot_d;
  lock_cnt_t lock_count;
  logic lock_done;

  // Captured straps and clock controls
  ratio_code_t ratio_q, ratio_d;
  boot_mode_t mode_q, mode_d;
  pll_mult_t mult_q, mult_d;
  div_code_t div_q, div_d;
  logic rr_mode_q, rr_mode_d; // Shared pin acts as running reset input

  // APB
  logic wr_en; // Write takes effect at this edge
  logic setup; // Read data is latched in setup
  logic [31:0] rd_q, rd_d;
  logic err_q, err_d;

  // Test output
  logic tdo_q, tdo_d;
  logic tdo_oe_n_q, tdo_oe_n_d;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  // Two flip-flops on each strap pin and the shared reset pin before any logic looks at it
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ratio_s1_q <= 2'h0;
      ratio_s2_q <= 2'h0;
      boot_s1_q <= 3'h0;
      boot_s2_q <= 3'h0;
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      ratio_s1_q <= CLK_RATIO_STRAP;
      ratio_s2_q <= ratio_s1_q;
      boot_s1_q <= BOOT_MODE_STRAP;
      boot_s2_q <= boot_s1_q;
      pin_s1_q <= RESET_PIN_I;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Lock interval runs only between hardware reset and first release
  pll_lock_timer u_lock (
    .clk(MCLK),
    .rstn(RSTN),
    .run(st_q == ST_LOCK),
    .count(lock_count),
    .done(lock_done)
  );

  // Sequencer next state; only RSTN or an unused code brings it back to LOCK
  always_comb begin
    st_d = st_q;
    fetch_d = 1'b0;
    boot_d = 1'b0;
    unique case (st_q)
      ST_LOCK: begin
        if (lock_done) begin
          st_d = ST_RUN;
          fetch_d = 1'b1;
          boot_d = 1'b1;
        end
      end
      ST_RUN: begin
        // Pin level only matters once software picked input mode
        if (rr_mode_q && !pin_s2_q) begin
          st_d = ST_RUNRST;
        end
      end
      ST_RUNRST: begin
        // Restart from the vector, but no boot and no PLL relock
        if (!rr_mode_q || pin_s2_q) begin
          st_d = ST_RUN;
          fetch_d = 1'b1;
        end
      end
      default: begin
        st_d = ST_LOCK; // Unused code goes to LOCK, left at once as the lock counter stays at its end
      end
    endcase
    core_rstn_d = (st_d == ST_RUN);
  end

  // Sequencer registers; RSTN is asserted by the board at power-up
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= ST_LOCK;
      core_rstn_q <= 1'b0;
      fetch_q <= 1'b0;
      boot_q <= 1'b0;
    end else begin
      st_q <= st_d;
      core_rstn_q <= core_rstn_d;
      fetch_q <= fetch_d;
      boot_q <= boot_d;
    end
  end

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign setup = PSEL && !PENABLE;

  // Straps and clock controls
  always_comb begin
    ratio_d = ratio_q;
    mode_d = mode_q;
    mult_d = mult_q;
    div_d = div_q;
    rr_mode_d = rr_mode_q;
    if (st_q == ST_LOCK) begin
      // Straps tracked until release; the last sample is the one kept
      ratio_d = ratio_s2_q;
      mode_d = boot_s2_q;
      mult_d = ratio_mult(ratio_s2_q);
      div_d = `DIV_RESET;
    end else if (wr_en && PADDR == `OFS_PCC && st_q == ST_RUN) begin
      // Writes while the core is held in reset are dropped
      mult_d = PWDATA[`PCC_MULT_MSB:`PCC_MULT_LSB];
      div_d = PWDATA[`PCC_DIV_MSB:`PCC_DIV_LSB];
    end
    if (wr_en && PADDR == `OFS_RRC) begin
      rr_mode_d = PWDATA[`RRC_MODE_BIT];
    end
  end

  // Control registers; running reset does not touch them
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ratio_q <= 2'h0;
      mode_q <= 3'h0;
      mult_q <= `MULT_RATIO_00;
      div_q <= `DIV_RESET;
      rr_mode_q <= 1'b0;
    end else begin
      ratio_q <= ratio_d;
      mode_q <= mode_d;
      mult_q <= mult_d;
      div_q <= div_d;
      rr_mode_q <= rr_mode_d;
    end
  end

  // Read mux and error, latched in the setup phase
  always_comb begin
    rd_d = rd_q;
    err_d = err_q;
    if (setup) begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      unique case (PADDR)
        `OFS_STATUS: begin
          rd_d[`ST_STATE_LSB+:2] = st_q;
          rd_d[`ST_RATIO_LSB+:2] = ratio_q;
          rd_d[`ST_BOOT_LSB+:3] = mode_q;
          rd_d[`ST_BADRATIO_BIT] = (ratio_q == 2'h3);
          rd_d[`ST_RUN_BIT] = core_rstn_q;
          rd_d[`ST_PIN_BIT] = pin_s2_q;
        end
        `OFS_PCC: begin
          rd_d[`PCC_MULT_MSB:`PCC_MULT_LSB] = mult_q;
          rd_d[`PCC_DIV_MSB:`PCC_DIV_LSB] = div_q;
        end
        `OFS_RRC: begin
          rd_d[`RRC_MODE_BIT] = rr_mode_q;
        end
        default: begin
          err_d = 1'b1; // Unmapped: zero data and an error
        end
      endcase
    end
  end

  // APB read registers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      err_q <= err_d;
    end
  end

  // Zero wait states; error only shown in the access phase
  assign PREADY = 1'b1;
  assign PRDATA = rd_q;
  assign PSLVERR = err_q && PSEL && PENABLE;

  // Test output floats through hardware reset and lock wait, and until the scan path runs
  always_comb begin
    tdo_d = SCAN_DATA;
    tdo_oe_n_d = !(SCAN_ACTIVE && st_q != ST_LOCK);
  end

  // Test output registers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_q <= tdo_d;
      tdo_oe_n_q <= tdo_oe_n_d;
    end
  end

  // Shared pin drives the core reset unless set up as an input
  assign RESET_PIN_O = core_rstn_q;
  assign RESET_PIN_OE_N = rr_mode_q;
  assign TDO_O = tdo_q;
  assign TDO_OE_N = tdo_oe_n_q;
  assign PLL_MULT = mult_q;
  assign PLL_DIV_VALUE = div_value(div_q);
  assign CORE_RSTN = core_rstn_q;
  assign PERIPH_RSTN = core_rstn_q;
  assign FETCH_START = fetch_q;
  assign FETCH_ADDR = `RESET_VECTOR;
  assign BOOT_START = boot_q;
  assign BOOT_MODE = mode_q;
  assign SEQ_STATE = st_q;

  // Lock end and the release that follows it
  sequence s_lock_end;
    st_q == ST_LOCK && lock_done;
  endsequence
  sequence s_release;
    CORE_RSTN && FETCH_START && BOOT_START;
  endsequence
  a_ratio_decode: assert property (
    st_q == ST_LOCK && !lock_done && ratio_s2_q == 2'h1
    |=> mult_q == 6'h20) else $error("ratio 01 not decoded as 32");
  a_strap_startup: assert property (
    st_q != ST_LOCK && !(wr_en && PADDR == `OFS_PCC)
    |=> $stable(mult_q)) else $error("strap changed clock after start");
  a_pcc_write: assert property (
    st_q == ST_RUN && wr_en && PADDR == `OFS_PCC
    |=> mult_q == $past(PWDATA[5:0]) && div_q == $past(PWDATA[9:8]))
    else $error("clock control write lost");
  a_lock_hold: assert property (
    st_q == ST_LOCK && !lock_done |=> !CORE_RSTN && st_q == ST_LOCK)
    else $error("core released before lock");
  a_vector_fetch: assert property (
    s_lock_end |-> lock_count == lock_cnt_t'(`LOCK_CYCLES - 1)
    ##1 s_release ##1 !FETCH_START && !BOOT_START)
    else $error("lock end did not start the core");
  a_pin_mode: assert property (
    RESET_PIN_OE_N ? rr_mode_q : RESET_PIN_O == (st_q == ST_RUN) && !rr_mode_q)
    else $error("shared reset pin direction wrong");
  a_tdo_quiet: assert property (
    st_q == ST_LOCK ##1 st_q == ST_LOCK |-> TDO_OE_N)
    else $error("test output driven during reset");
  a_runrst_spare: assert property (
    st_q == ST_RUNRST |-> !CORE_RSTN ##1 !BOOT_START && $stable(mult_q))
    else $error("running reset disturbed clock or booted");
  a_div_default: assert property (
    st_q == ST_LOCK |-> PLL_DIV_VALUE == 5'h02)
    else $error("post divider not two in reset");
  a_reset_out: assert property (
    !rr_mode_q && st_q == ST_LOCK |-> !RESET_PIN_O && !RESET_PIN_OE_N)
    else $error("reset output released too early");
endmodule : reset_clock_boot_ctrl

// ==== board_model.sv ====
// Board side model: reset supervisor, strap resistors, shared pin pull-up.
// Assumes the bench issues requests on the rising edge of mclk.
`timescale 1ns/100ps
module board_model (
  // Clock
  input wire logic mclk,
  // Bench requests
  input wire logic rst_req,
  input wire logic pull_low,
  input wire logic [1:0] ratio,
  input wire logic [2:0] boot,
  // Pins toward the device
  output logic rstn,
  output logic [1:0] ratio_strap,
  output logic [2:0] boot_strap,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic pin_i,
  // Test access port pins, held low from power-up
  output logic tap_trst_n,
  output logic tap_tck
);
  // Holding both low is the simplest legal choice for the board
  assign tap_trst_n = 1'b0;
  assign tap_tck = 1'b0;
  // Power-up: reset low, straps already wired to a valid code
  initial begin
    rstn = 1'b0;
    ratio_strap = 2'h0;
    boot_strap = 3'h0;
  end
  // Straps follow the bench request on every edge, like the reset
  always @(posedge mclk) begin
    rstn <= !rst_req;
    ratio_strap <= ratio;
    boot_strap <= boot;
  end
  // Device drive wins; else board pull-down; else pull-up on the pin
  assign pin_i = !pin_oe_n ? pin_o : !pull_low;
endmodule : board_model

// ==== test_reset_clock_boot_strap_control.sv ====
// Bench for start-up control: straps, lock wait, APB, running reset, TDO.
// Assumes rcb_pkg and rcb_cfg.svh are compiled first.
`timescale 1ns/100ps
`include "rcb_cfg.svh"
module test_reset_clock_boot_strap_control;
  import rcb_pkg::*;
  logic mclk, rst_req, pull_low, rstn, pin_i, pin_o, pin_oe_n, err;
  logic psel, penable, pwrite, pready, pslverr, scan_act, scan_dat;
  logic tdo_o, tdo_oe_n, core_rstn, periph_rstn, fetch, boot_go;
  logic tap_trst_n, tap_tck;
  logic [1:0] ratio, ratio_strap;
  logic [2:0] boot, boot_strap;
  logic [4:0] divv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, faddr, rd;
  pll_mult_t mult;
  boot_mode_t bmode;
  seq_state_t state;
  int fails, tests_run, n;
  reset_clock_boot_ctrl i_reset_clock_boot_ctrl (.MCLK(mclk), .RSTN(rstn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CLK_RATIO_STRAP(ratio_strap), .BOOT_MODE_STRAP(boot_strap),
    .RESET_PIN_I(pin_i), .RESET_PIN_O(pin_o), .RESET_PIN_OE_N(pin_oe_n),
    .SCAN_ACTIVE(scan_act), .SCAN_DATA(scan_dat), .TDO_O(tdo_o),
    .TDO_OE_N(tdo_oe_n), .PLL_MULT(mult), .PLL_DIV_VALUE(divv),
    .CORE_RSTN(core_rstn), .PERIPH_RSTN(periph_rstn), .FETCH_START(fetch),
    .FETCH_ADDR(faddr), .BOOT_START(boot_go), .BOOT_MODE(bmode),
    .SEQ_STATE(state));
  board_model i_board_model (.mclk(mclk), .rst_req(rst_req),
    .pull_low(pull_low), .ratio(ratio), .boot(boot), .rstn(rstn),
    .ratio_strap(ratio_strap), .boot_strap(boot_strap), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .pin_i(pin_i), .tap_trst_n(tap_trst_n),
    .tap_tck(tap_tck));
  // Free-running reference clock, never stopped
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Compare and count; X never matches
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready, read data kept in rd
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog bounds this wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Wait up to a bound for core reset to reach a level; n counts edges
  task wait_core(input logic lvl);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (core_rstn !== lvl && n < 5000);
  endtask : wait_core
  // Hardware reset with given straps, checks held state, then lock wait
  task hw_reset(input logic [1:0] r, input logic [2:0] b);
    @(posedge mclk);
    ratio <= r;
    boot <= b;
    rst_req <= 1'b1;
    repeat (16) @(posedge mclk);
    #1;
    chk(core_rstn, 0, "core held");
    chk(pin_o, 0, "pin low");
    chk(pin_oe_n, 0, "pin driven");
    chk(tdo_oe_n, 1, "tdo float");
    chk(divv, 2, "div in reset");
    chk(state, ST_LOCK, "lock state");
    chk({tap_trst_n, tap_tck}, 2'h0, "tap held low");
    @(posedge mclk);
    rst_req <= 1'b0;
    @(posedge rstn);
    wait_core(1'b1);
  endtask : hw_reset
  // Give the verdict and stop
  task give_verdict;
    $display("Compares %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  // Hang guard, well beyond five lock waits
  initial begin
    #400_000;
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    give_verdict();
  end
  // Main sequence
  initial begin
    fails = 0;
    tests_run = 0;
    rst_req = 1'b1;
    pull_low = 1'b0;
    ratio = 2'h0;
    boot = 3'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    scan_act = 1'b1;
    scan_dat = 1'b1;
    // Every ratio code, also reserved, with a reset in mid-run
    for (int i = 0; i < 4; i++) begin
      hw_reset(i[1:0], {1'b1, i[1:0]});
      chk(n, `LOCK_CYCLES, "lock wait");
      chk(mult, i == 1 ? 6'h20 : i == 2 ? 6'h10 : 6'h08, "mult");
      chk(bmode, {1'b1, i[1:0]}, "boot mode");
      chk(faddr, `RESET_VECTOR, "vector");
      chk({fetch, boot_go, pin_o}, 3'h7, "start pulses");
      @(posedge mclk);
      #1;
      chk({fetch, boot_go}, 2'h0, "pulses end");
      chk({tdo_oe_n, tdo_o}, 2'h1, "tdo driven");
      $display("Test reset with ratio %0d done", i);
    end
    // Register map: status, reset values, unmapped, reprogramming
    apb(1'b1, 8'h00, 32'hffff_ffff);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, {22'h0, 3'h7, 3'h7, 2'h3, 2'h1}, "status");
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_0008, "clock ctl reset");
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "run reset ctl");
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk({err, rd}, {1'b1, 32'h0000_0000}, "unmapped");
    apb(1'b1, 8'h04, 32'h0000_020c);
    #1;
    chk({mult, divv}, {6'h0c, 5'h08}, "reprogram");
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_020c, "clock ctl back");
    @(posedge mclk);
    scan_dat <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(tdo_o, 0, "scan data");
    $display("Test registers and scan done");
    // Running reset through the shared pin
    apb(1'b1, 8'h08, 32'h0000_0001);
    #1;
    chk(pin_oe_n, 1, "pin as input");
    @(posedge mclk);
    pull_low <= 1'b1;
    wait_core(1'b0);
    chk(n > 0 && n < 5, 1, "run reset in");
    chk({periph_rstn, state}, {1'b0, ST_RUNRST}, "run reset");
    apb(1'b1, 8'h04, 32'h0000_0110);
    #1;
    chk({mult, divv}, {6'h0c, 5'h08}, "pll kept");
    @(posedge mclk);
    pull_low <= 1'b0;
    wait_core(1'b1);
    chk(n > 0 && n < 5, 1, "run reset out");
    chk({fetch, boot_go}, 2'h2, "no boot");
    apb(1'b1, 8'h08, 32'h0000_0000);
    #1;
    chk({pin_oe_n, pin_o}, 2'h1, "pin output");
    $display("Test running reset done");
    give_verdict();
  end
endmodule : test_reset_clock_boot_strap_control
